// file: phy_common_test_control.v
// USB PHY common block control and status register with APB slave
//
// How it works
// R1: Bit 31 set gates off clocks to the common block registers.
// R2: Bit 24 picks functional (0) or test (1) signals into common block.
// R3: Bit 23 drives crystal amplitude: 0 is 0.9V, 1 is 1V.
// R4: Bit 19 picks PLL reference: 0 is 25 MHz at reset, 1 is 24 MHz.
// R5: Bit 18 reads core supply ready, forced low without 3V power-on.
// R6: Bit 17 set enables fast start of the high-speed PLL.
// R7: Bit 16 enables the high-speed PLL and resets to 1.
// R8: Bit 15 low powers down bias, PLLs, local suspends and analog blocks.
// R9: Bit 14 low powers down crystal; may run under low-power hold.
// R10: Bit 12 reads whether PLL clocks are usable, reset 0.
// R11: Bit 11 enables superspeed transmit PLL; bit 10 reads it usable.
// R12: Bit 9 set disables the analog front-end ready timer.
// R13: Bit 0 set forces every clock gating cell into bypass.
// R14: Bit 17 default comes from EEPROM, else OTP, else 0.
// R15: Default for bit 17 depends on high-speed or full-speed mode.
// R16: Bus reset or lite reset restores bit 17 to its loaded default.
// R17: Reserved bits read zero and ignore writes.
//
// Register access over APB is this design's own decision.
`include "phy_common_test_control_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module phy_common_test_control
(
  input  wire                     clk_in,
  input  wire                     rst_n_in,
  // APB slave
  input  wire                     psel_in,
  input  wire                     penable_in,
  input  wire                     pwrite_in,
  input  wire [`PCT_ADDR_W-1:0]   paddr_in,
  input  wire [31:0]              pwdata_in,
  input  wire [3:0]               pstrb_in,
  output reg  [31:0]              prdata_out,
  output wire                     pready_out,
  output wire                     pslverr_out,
  // Configuration image and resets, same clock
  input  wire                     config_load_in,
  input  wire                     eeprom_present_in,
  input  wire                     eeprom_lpm_hs_in,
  input  wire                     eeprom_lpm_fs_in,
  input  wire                     otp_valid_in,
  input  wire                     otp_lpm_hs_in,
  input  wire                     otp_lpm_fs_in,
  input  wire                     hs_mode_in,
  input  wire                     usb_reset_in,
  input  wire                     lite_reset_in,
  input  wire                     lpm_hold_in,
  // Analog status, asynchronous
  input  wire                     pll_usable_in,
  input  wire                     ss_pll_usable_in,
  input  wire                     core_supply_ok_in,
  input  wire                     por_3v_ok_in,
  // Common block signal steering
  input  wire [`PCT_CTRL_W-1:0]   func_ctrl_in,
  input  wire [`PCT_CTRL_W-1:0]   test_ctrl_in,
  output reg  [`PCT_CTRL_W-1:0]   common_ctrl_out,
  input  wire [`PCT_LOCAL_W-1:0]  local_suspend_n_in,
  output reg  [`PCT_LOCAL_W-1:0]  local_suspend_n_out,
  // Analog controls
  output reg                      common_clk_en_out,
  output reg                      clock_gate_bypass_out,
  output reg                      crystal_gain_out,
  output reg                      ref_freq_24m_out,
  output reg                      hs_pll_en_out,
  output reg                      pll_fast_start_out,
  output reg                      common_suspend_n_out,
  output reg                      afe_power_down_out,
  output reg                      crystal_suspend_n_out,
  output reg                      ss_tx_pll_en_out,
  output reg                      ready_timer_disable_out,
  output reg                      afe_ready_out
);

  localparam TMR_IDLE  = 2'b00;
  localparam TMR_COUNT = 2'b01;
  localparam TMR_READY = 2'b10;

  // Terminal count, cut to the counter width on purpose
  // Ten bits only; a longer ready time needs a wider PCT_TMR_W
  localparam integer          TMR_LAST_I = `PCT_AFE_READY_CYC - 1;
  localparam [`PCT_TMR_W-1:0] TMR_LAST   = TMR_LAST_I[`PCT_TMR_W-1:0];
  localparam [`PCT_TMR_W-1:0] TMR_ZERO = 10'h000;
  localparam [`PCT_TMR_W-1:0] TMR_ONE  = 10'h001;

  // Byte-lane merge of a write into the held control word
  // Strobes let software touch one byte lane without a read first
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strobes;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (strobes[i])
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  // Anything fed from the common bias drops with it
  function bias_gate;
    input enable;
    input bias_on;
    begin
      bias_gate = enable & bias_on;
    end
  endfunction

  reg  [31:0]               ctl_r;
  reg  [31:0]               ctl_nxt;
  reg  [1:0]                tmr_state_r;
  reg  [1:0]                tmr_state_nxt;
  reg  [`PCT_TMR_W-1:0]     tmr_cnt_r;
  reg  [`PCT_TMR_W-1:0]     tmr_cnt_nxt;
  reg  [31:0]               read_word;

  wire [`PCT_STATUS_W-1:0]  status_raw;
  wire [`PCT_STATUS_W-1:0]  status_sync;
  wire                      pll_usable;
  wire                      ss_pll_usable;
  wire                      core_supply_ok;
  wire                      por_3v_ok;
  wire                      lpm_default;
  wire                      lpm_loaded;
  wire                      addr_hit;
  wire                      setup_phase;
  wire                      wr_access;
  wire                      restore_lpm;
  wire                      core_por_flag;

  assign status_raw = {por_3v_ok_in, core_supply_ok_in,
                       ss_pll_usable_in, pll_usable_in};

  // Status reads settle four to five edges after a pin moves
  status_sync3
  #(
    .W (`PCT_STATUS_W)
  )
  u_status_sync
  (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (status_raw),
    .level_out (status_sync)
  );

  assign pll_usable     = status_sync[0];
  assign ss_pll_usable  = status_sync[1];
  assign core_supply_ok = status_sync[2];
  assign por_3v_ok      = status_sync[3];

  // Bit 17 default from the image and the bus speed [R14] [R15]
  lpm_default_loader u_lpm_loader
  (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .config_load_in    (config_load_in),
    .eeprom_present_in (eeprom_present_in),
    .eeprom_lpm_hs_in  (eeprom_lpm_hs_in),
    .eeprom_lpm_fs_in  (eeprom_lpm_fs_in),
    .otp_valid_in      (otp_valid_in),
    .otp_lpm_hs_in     (otp_lpm_hs_in),
    .otp_lpm_fs_in     (otp_lpm_fs_in),
    .hs_mode_in        (hs_mode_in),
    .lpm_default_out   (lpm_default),
    .loaded_out        (lpm_loaded)
  );

  // Zero-wait slave; any other word answers with an error
  assign addr_hit    = (paddr_in == `PCT_OFFSET);
  assign setup_phase = psel_in & ~penable_in;
  assign wr_access   = psel_in & penable_in & pwrite_in & addr_hit;
  assign pready_out  = 1'b1;
  // Unmapped writes are dropped; the error tells software why
  assign pslverr_out = psel_in & penable_in & ~addr_hit;

  // Image load, bus reset and lite reset all put the default back [R16]
  assign restore_lpm = lpm_loaded | usb_reset_in | lite_reset_in;

  // Core ready only counts while the 3V supply is up [R5]
  assign core_por_flag = core_supply_ok & por_3v_ok;

  // Control word next value
  always @*
  begin
    ctl_nxt = ctl_r;
    if (wr_access)
      ctl_nxt = lane_merge(ctl_r, pwdata_in, pstrb_in) & `PCT_WR_MASK; // [R17]
    // Restore beats a same-cycle write so a reset is never lost
    if (restore_lpm)
      ctl_nxt[`PCT_FAST_START_BIT] = lpm_default; // [R14] [R16]
  end

  // Bit 16 comes out of reset set, bit 17 clear until the image loads
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctl_r <= `PCT_RESET_VAL; // [R7] [R4]
    else
      ctl_r <= ctl_nxt;
  end

  // Read view: held control bits plus live status, reserved as zero
  always @*
  begin
    read_word = ctl_r & `PCT_WR_MASK; // [R17]
    read_word[`PCT_CORE_POR_BIT]   = core_por_flag;  // [R5]
    read_word[`PCT_PLL_USABLE_BIT] = pll_usable;     // [R10]
    read_word[`PCT_SS_USABLE_BIT]  = ss_pll_usable;  // [R11]
  end

  // Read data captured in the setup cycle, held through the access
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prdata_out <= `PCT_ZERO_WORD;
    else if (setup_phase)
    begin
      if (addr_hit && !pwrite_in)
        prdata_out <= read_word;
      else
        prdata_out <= `PCT_ZERO_WORD;
    end
  end

  // Ready timer; a disabled timer reports ready as soon as bias is up
  always @*
  begin
    tmr_state_nxt = tmr_state_r;
    tmr_cnt_nxt   = tmr_cnt_r;
    case (tmr_state_r)
      TMR_IDLE:
      begin
        tmr_cnt_nxt = TMR_ZERO;
        if (ctl_r[`PCT_COM_SUSP_N_BIT])
        begin
          if (ctl_r[`PCT_RDY_TMR_DIS_BIT])
            tmr_state_nxt = TMR_READY; // [R12]
          else
            tmr_state_nxt = TMR_COUNT;
        end
      end
      TMR_COUNT:
      begin
        if (!ctl_r[`PCT_COM_SUSP_N_BIT])
          tmr_state_nxt = TMR_IDLE; // [R8]
        else if (ctl_r[`PCT_RDY_TMR_DIS_BIT] || tmr_cnt_r == TMR_LAST)
          tmr_state_nxt = TMR_READY; // [R12]
        else
          tmr_cnt_nxt = tmr_cnt_r + TMR_ONE;
      end
      TMR_READY:
      begin
        if (!ctl_r[`PCT_COM_SUSP_N_BIT])
          tmr_state_nxt = TMR_IDLE; // [R8]
      end
      default:
      begin
        tmr_state_nxt = TMR_IDLE;
        tmr_cnt_nxt   = TMR_ZERO;
      end
    endcase
  end

  // Timer state and count
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tmr_state_r <= TMR_IDLE;
      tmr_cnt_r   <= TMR_ZERO;
    end
    else
    begin
      tmr_state_r <= tmr_state_nxt;
      tmr_cnt_r   <= tmr_cnt_nxt;
    end
  end

  // Registered drive of the analog controls. Outputs settle one edge
  // after the register changes, which keeps glitches off analog pins.
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      common_clk_en_out       <= 1'b1;
      clock_gate_bypass_out   <= 1'b0;
      crystal_gain_out        <= 1'b0;
      ref_freq_24m_out        <= 1'b0;
      hs_pll_en_out           <= 1'b0;
      pll_fast_start_out      <= 1'b0;
      common_suspend_n_out    <= 1'b0;
      afe_power_down_out      <= 1'b1;
      crystal_suspend_n_out   <= 1'b0;
      ss_tx_pll_en_out        <= 1'b0;
      ready_timer_disable_out <= 1'b0;
      afe_ready_out           <= 1'b0;
      common_ctrl_out         <= {`PCT_CTRL_W{1'b0}};
      local_suspend_n_out     <= {`PCT_LOCAL_W{1'b0}};
    end
    else
    begin
      // Enable for an external gate cell; gating this logic itself
      // would leave software no way back in
      common_clk_en_out     <= ~ctl_r[`PCT_CLK_GATE_OFF_BIT]; // [R1]
      clock_gate_bypass_out <= ctl_r[`PCT_CG_BYPASS_BIT];     // [R13]
      crystal_gain_out      <= ctl_r[`PCT_XTAL_GAIN_BIT];     // [R3]
      ref_freq_24m_out      <= ctl_r[`PCT_REF_FREQ_BIT];      // [R4]
      ready_timer_disable_out <= ctl_r[`PCT_RDY_TMR_DIS_BIT]; // [R12]
      common_suspend_n_out  <= ctl_r[`PCT_COM_SUSP_N_BIT];    // [R8]
      afe_power_down_out    <= ~ctl_r[`PCT_COM_SUSP_N_BIT];   // [R8]
      // PLLs stay down while the common block is suspended
      hs_pll_en_out <= bias_gate(ctl_r[`PCT_HS_PLL_EN_BIT],
                                 ctl_r[`PCT_COM_SUSP_N_BIT]); // [R7] [R8]
      ss_tx_pll_en_out <= bias_gate(ctl_r[`PCT_SS_PLL_EN_BIT],
                                    ctl_r[`PCT_COM_SUSP_N_BIT]); // [R11] [R8]
      pll_fast_start_out <= ctl_r[`PCT_FAST_START_BIT];       // [R6]
      // Crystal may keep running under the low-power hold
      crystal_suspend_n_out <= ctl_r[`PCT_XTAL_SUSP_N_BIT] |
                               (lpm_hold_in &
                                ctl_r[`PCT_FAST_START_BIT]);  // [R9]
      // Common suspend overrides every local suspend
      local_suspend_n_out <= local_suspend_n_in &
        {`PCT_LOCAL_W{ctl_r[`PCT_COM_SUSP_N_BIT]}};           // [R8]
      afe_ready_out <= bias_gate(tmr_state_r == TMR_READY,
                                 ctl_r[`PCT_COM_SUSP_N_BIT]); // [R12] [R8]
      // Steering is registered, so a select change takes one edge
      if (ctl_r[`PCT_TEST_SEL_BIT])
        common_ctrl_out <= test_ctrl_in;                      // [R2]
      else
        common_ctrl_out <= func_ctrl_in;                      // [R2]
    end
  end

endmodule // phy_common_test_control

`default_nettype wire

// file: phy_common_test_control_defines.vh
// Register map, field positions, reset values and timing for the control bank
`ifndef PHY_COMMON_TEST_CONTROL_DEFINES_VH
`define PHY_COMMON_TEST_CONTROL_DEFINES_VH

// APB address width and the one mapped word
`define PCT_ADDR_W            12
`define PCT_OFFSET            12'h000

// Field positions
`define PCT_CLK_GATE_OFF_BIT  31
`define PCT_TEST_SEL_BIT      24
`define PCT_XTAL_GAIN_BIT     23
`define PCT_REF_FREQ_BIT      19
`define PCT_CORE_POR_BIT      18
`define PCT_FAST_START_BIT    17
`define PCT_HS_PLL_EN_BIT     16
`define PCT_COM_SUSP_N_BIT    15
`define PCT_XTAL_SUSP_N_BIT   14
`define PCT_PLL_USABLE_BIT    12
`define PCT_SS_PLL_EN_BIT     11
`define PCT_SS_USABLE_BIT     10
`define PCT_RDY_TMR_DIS_BIT   9
`define PCT_CG_BYPASS_BIT     0

// Reset value, writable bits and hardware status bits
`define PCT_RESET_VAL         32'h0001_0000
`define PCT_WR_MASK           32'h818B_CA01
`define PCT_RO_MASK           32'h0004_1400
`define PCT_ZERO_WORD         32'h0000_0000

// Widths of the side buses
`define PCT_CTRL_W            8
`define PCT_LOCAL_W           4
`define PCT_STATUS_W          4

// Analog front-end ready timer
`define PCT_CLK_PERIOD_NS     20
`define PCT_AFE_READY_NS      10000
`define PCT_AFE_READY_CYC     ((`PCT_AFE_READY_NS + `PCT_CLK_PERIOD_NS - 1) \
                               / `PCT_CLK_PERIOD_NS)
`define PCT_TMR_W             10

`endif

// file: status_sync3.v
// Three-stage synchroniser with agreement filter for analog status levels
`timescale 1ns/10ps
`default_nettype none

module status_sync3
#(
  parameter W = 4
)
(
  input  wire         clk_in,
  input  wire         rst_n_in,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] level_out
);

  reg [W-1:0] stage1_r;
  reg [W-1:0] stage2_r;
  reg [W-1:0] stage3_r;

  // Only stage2 reads stage1; a bit counts once stages 2 and 3 agree
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1_r  <= {W{1'b0}};
      stage2_r  <= {W{1'b0}};
      stage3_r  <= {W{1'b0}};
      level_out <= {W{1'b0}};
    end
    else
    begin
      stage1_r  <= async_in;
      stage2_r  <= stage1_r;
      stage3_r  <= stage2_r;
      level_out <= (stage2_r & stage3_r) | (level_out & (stage2_r | stage3_r));
    end
  end

endmodule // status_sync3

`default_nettype wire

// file: lpm_default_loader.v
// Holds the fast-start defaults taken from the configuration image
`timescale 1ns/10ps
`default_nettype none

module lpm_default_loader
(
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire config_load_in,
  input  wire eeprom_present_in,
  input  wire eeprom_lpm_hs_in,
  input  wire eeprom_lpm_fs_in,
  input  wire otp_valid_in,
  input  wire otp_lpm_hs_in,
  input  wire otp_lpm_fs_in,
  input  wire hs_mode_in,
  output wire lpm_default_out,
  output reg  loaded_out
);

  reg image_hs_r;
  reg image_fs_r;

  // EEPROM first, then OTP, else zero [R14]
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      image_hs_r <= 1'b0;
      image_fs_r <= 1'b0;
      loaded_out <= 1'b0;
    end
    else
    begin
      loaded_out <= config_load_in;
      if (config_load_in)
      begin
        if (eeprom_present_in)
        begin
          image_hs_r <= eeprom_lpm_hs_in;
          image_fs_r <= eeprom_lpm_fs_in;
        end
        else if (otp_valid_in)
        begin
          image_hs_r <= otp_lpm_hs_in;
          image_fs_r <= otp_lpm_fs_in;
        end
        else
        begin
          image_hs_r <= 1'b0;
          image_fs_r <= 1'b0;
        end
      end
    end
  end

  // Flag follows the current bus speed [R15]
  assign lpm_default_out = hs_mode_in ? image_hs_r : image_fs_r;

endmodule // lpm_default_loader

`default_nettype wire

// file: phy_common_test_control_monitor.sv
// Port assertions for the common block control register
`include "phy_common_test_control_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module phy_common_test_control_monitor
(
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   psel_in,
  input wire logic                   penable_in,
  input wire logic                   pwrite_in,
  input wire logic [`PCT_ADDR_W-1:0] paddr_in,
  input wire logic [31:0]            pwdata_in,
  input wire logic [3:0]             pstrb_in,
  input wire logic [31:0]            prdata_out,
  input wire logic                   lpm_hold_in,
  input wire logic                   por_3v_ok_in,
  input wire logic [3:0]             local_suspend_n_out,
  input wire logic                   common_clk_en_out,
  input wire logic                   clock_gate_bypass_out,
  input wire logic                   hs_pll_en_out,
  input wire logic                   pll_fast_start_out,
  input wire logic                   common_suspend_n_out,
  input wire logic                   afe_power_down_out,
  input wire logic                   crystal_suspend_n_out,
  input wire logic                   ss_tx_pll_en_out,
  input wire logic                   ready_timer_disable_out,
  input wire logic                   afe_ready_out
);
  wire acc = psel_in & penable_in & (paddr_in == `PCT_OFFSET);
  wire wr_hit = acc & pwrite_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_clock_gate_write: assert property (
    wr_hit && pstrb_in[3] |=> ##1
      common_clk_en_out == !$past(pwdata_in[`PCT_CLK_GATE_OFF_BIT], 2))
    else $error("clock enable ignores write");
  a_bypass_write: assert property (
    wr_hit && pstrb_in[0] |=> ##1
      clock_gate_bypass_out == $past(pwdata_in[`PCT_CG_BYPASS_BIT], 2))
    else $error("bypass ignores write");
  a_timer_dis_write: assert property (
    wr_hit && pstrb_in[1] |=> ##1
      ready_timer_disable_out == $past(pwdata_in[9], 2))
    else $error("timer disable ignores write");
  a_suspend_power: assert property (
    !common_suspend_n_out |-> afe_power_down_out && local_suspend_n_out == 4'h0
      && !hs_pll_en_out && !ss_tx_pll_en_out)
    else $error("suspend leaves analog powered");
  a_reserved_zero: assert property (
    acc && !pwrite_in |-> (prdata_out & ~(`PCT_WR_MASK | `PCT_RO_MASK)) == 0)
    else $error("reserved bits read nonzero");
  a_por_gate: assert property (
    (!por_3v_ok_in)[*8] ##1 (acc && !pwrite_in) |-> !prdata_out[18])
    else $error("core ready seen without power-on");
  a_crystal_hold: assert property (
    $past(lpm_hold_in) && pll_fast_start_out |-> crystal_suspend_n_out)
    else $error("crystal suspended during hold");
  a_afe_ready_fast: assert property (
    $rose(ready_timer_disable_out) && common_suspend_n_out |-> ##[0:3]
      afe_ready_out)
    else $error("ready late with timer disabled");
  c_write: cover property (wr_hit);
  c_ready: cover property ($rose(afe_ready_out));
  c_suspend: cover property ($fell(common_suspend_n_out));
endmodule // phy_common_test_control_monitor

bind phy_common_test_control phy_common_test_control_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .lpm_hold_in(lpm_hold_in), .por_3v_ok_in(por_3v_ok_in),
  .local_suspend_n_out(local_suspend_n_out),
  .common_clk_en_out(common_clk_en_out),
  .clock_gate_bypass_out(clock_gate_bypass_out),
  .hs_pll_en_out(hs_pll_en_out), .pll_fast_start_out(pll_fast_start_out),
  .common_suspend_n_out(common_suspend_n_out),
  .afe_power_down_out(afe_power_down_out),
  .crystal_suspend_n_out(crystal_suspend_n_out),
  .ss_tx_pll_en_out(ss_tx_pll_en_out),
  .ready_timer_disable_out(ready_timer_disable_out),
  .afe_ready_out(afe_ready_out)
);
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the common block control register
`include "phy_common_test_control_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk_in, rst_n_in, psel, pen, pwr, cfg, ee_p, otp_v, hs, err;
  logic        usb_rst, lite_rst, hold, pll_ok, ss_ok, core_ok, por_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0]  pstrb, lsn_in;
  logic [7:0]  fctl, tctl;
  logic [4:0]  tv [5];
  wire  [31:0] prdata;
  wire  [3:0]  lsn_out;
  wire  [7:0]  cctl;
  wire  [10:0] o;
  wire         pready, perr, ready;
  int          miscompares, checks, n;

  phy_common_test_control dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .config_load_in(cfg), .eeprom_present_in(ee_p), .eeprom_lpm_hs_in(1'b1),
    .eeprom_lpm_fs_in(1'b0), .otp_valid_in(otp_v), .otp_lpm_hs_in(1'b0),
    .otp_lpm_fs_in(1'b1), .hs_mode_in(hs), .usb_reset_in(usb_rst),
    .lite_reset_in(lite_rst), .lpm_hold_in(hold), .pll_usable_in(pll_ok),
    .ss_pll_usable_in(ss_ok), .core_supply_ok_in(core_ok),
    .por_3v_ok_in(por_ok), .func_ctrl_in(fctl), .test_ctrl_in(tctl),
    .common_ctrl_out(cctl), .local_suspend_n_in(lsn_in),
    .local_suspend_n_out(lsn_out), .common_clk_en_out(o[10]),
    .clock_gate_bypass_out(o[9]), .crystal_gain_out(o[8]),
    .ref_freq_24m_out(o[7]), .hs_pll_en_out(o[6]),
    .pll_fast_start_out(o[5]), .common_suspend_n_out(o[4]),
    .afe_power_down_out(o[3]), .crystal_suspend_n_out(o[2]),
    .ss_tx_pll_en_out(o[1]), .ready_timer_disable_out(o[0]),
    .afe_ready_out(ready)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  // Read data and error are taken only at the edge that sees pready high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_in);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clk_in);
    pen <= 1'b1;
    do
      @(posedge clk_in);
    while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Whole run is near 700 cycles; allow 5000
  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    {psel, pen, pwr, cfg, ee_p, otp_v, hs, usb_rst, lite_rst, hold} = '0;
    {pll_ok, ss_ok, core_ok, por_ok, rst_n_in} = '0;
    {paddr, pwdata, pstrb} = '0;
    lsn_in = 4'hF;
    fctl = 8'hA5;
    tctl = 8'h3C;
    tv = '{5'h1E, 5'h19, 5'h0A, 5'h0D, 5'h04};
    cyc(5);
    rst_n_in <= 1'b1;
    rdc(12'h000, `PCT_RESET_VAL);
    chk({21'h0, o}, 32'h0000_0408);
    xfer(1'b1, 12'h000, 32'hFFFF_FFFF, 4'hF);
    rdc(12'h000, `PCT_WR_MASK);
    chk({21'h0, o}, 32'h0000_03F7);
    xfer(1'b1, 12'h000, 32'h0101_0800, 4'hF);
    cyc(2);
    chk({cctl, lsn_out, 9'h0, o}, {8'h3C, 4'h0, 9'h0, 11'h408});
    xfer(1'b1, 12'h000, 32'h0001_8800, 4'hF);
    cyc(2);
    chk({cctl, lsn_out, 9'h0, o}, {8'hA5, 4'hF, 9'h0, 11'h452});
    hold <= 1'b1;
    xfer(1'b1, 12'h000, 32'h0002_8000, 4'hF);
    cyc(2);
    chk({21'h0, o}, 32'h0000_0434);
    hold <= 1'b0;
    cyc(2);
    chk({21'h0, o}, 32'h0000_0430);
    xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
    xfer(1'b1, 12'h000, 32'h0000_8000, 4'hF);
    n = 0;
    while (ready !== 1'b1 && n < 600)
    begin
      cyc(1);
      n++;
    end
    chk({31'h0, n > 490 && n < 510}, 32'h1);
    xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
    cyc(3);
    chk({31'h0, ready}, 32'h0);
    xfer(1'b1, 12'h000, 32'h0000_8200, 4'hF);
    cyc(4);
    chk({31'h0, ready}, 32'h1);
    {pll_ok, ss_ok, core_ok} <= 3'h7;
    cyc(8);
    rdc(12'h000, 32'h0000_9600);
    por_ok <= 1'b1;
    cyc(8);
    rdc(12'h000, 32'h0004_9600);
    xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
    rdc(12'h000, 32'h0004_1400);
    xfer(1'b1, 12'h000, 32'hFFFF_FFFF, 4'h1);
    rdc(12'h000, 32'h0004_1401);
    xfer(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
    chk({31'h0, err}, 32'h1);
    rdc(12'h004, 32'h0);
    rdc(12'h000, 32'h0004_1401);
    // Each case: source flags, mode, expected default, which reset
    for (int i = 0; i < 5; i++)
    begin
      {ee_p, otp_v, hs} <= tv[i][4:2];
      cyc(1);
      cfg <= 1'b1;
      cyc(1);
      cfg <= 1'b0;
      cyc(3);
      xfer(1'b0, 12'h000, 32'h0, 4'h0);
      chk({31'h0, rd[17]}, {31'h0, tv[i][1]});
      xfer(1'b1, 12'h000, {14'h0, ~tv[i][1], 17'h0}, 4'h4);
      usb_rst  <= ~tv[i][0];
      lite_rst <= tv[i][0];
      cyc(1);
      {usb_rst, lite_rst} <= 2'b00;
      cyc(2);
      xfer(1'b0, 12'h000, 32'h0, 4'h0);
      chk({31'h0, rd[17]}, {31'h0, tv[i][1]});
    end
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
